// ==== core/spq_top.sv ====
// Phase sequencer with control, status and interrupt registers on AXI4-Lite
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module spq_top #(
   parameter int ADDR_W = 8,
   parameter int NPHASE = 8
) (
   // Clock, reset, enable
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic CE,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Serial engine
   output logic PHASE_REQ,
   output logic [2:0] PHASE_IDX,
   output spq_pkg::spq_phase_s PHASE_CFG,
   input wire logic PHASE_ACK,
   input wire logic PHASE_FAIL,
   // DMA
   input wire logic DMA_DONE,
   // Status
   output logic BUSY,
   output logic IRQ
);
   spq_pkg::spq_state_e state_q, state_d;
   spq_pkg::spq_phase_s cfg_q [NPHASE];
   logic [2:0] pcnt_q, pcnt_d;
   logic done_q, done_d, err_q, err_d, fail_q, fail_d;
   logic [2:0] idx_q, idx_d;
   logic [NPHASE-1:0] ph_done_q, ph_err_q;
   logic [1:0] istat_q, istat_d, imask_q, imask_d;
   logic aw_held_q, w_held_q, aw_held_d, w_held_d;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic req_q, busy_q, irq_q;
   logic [2:0] pidx_q;
   spq_pkg::spq_phase_s pcfg_q;

   function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
      logic [7:0] b;
      b = a[7:0];
      if (b == spq_pkg::CTRL_OFS)
         return spq_pkg::SEL_CTRL;
      if (b >= spq_pkg::PHASE0_OFS && b <= spq_pkg::PHASE_LAST_OFS && b[1:0] == 2'h0)
         return spq_pkg::SEL_PHASE;
      if (b == spq_pkg::INT_STAT_OFS)
         return spq_pkg::SEL_ISTAT;
      if (b == spq_pkg::INT_MASK_OFS)
         return spq_pkg::SEL_IMASK;
      if (b == spq_pkg::STATUS_OFS)
         return spq_pkg::SEL_STATUS;
      return spq_pkg::SEL_NONE;
   endfunction

   function automatic logic [2:0] ph_index(input logic [ADDR_W-1:0] a);
      logic [7:0] d;
      d = a[7:0] - spq_pkg::PHASE0_OFS;
      return d[4:2];
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i])
            r[8*i +: 8] = n[8*i +: 8];
      end
      return r;
   endfunction

   function automatic logic [31:0] ph_word(input spq_pkg::spq_phase_s c, input logic e,
                                           input logic d);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[spq_pkg::PH_MODE_LSB +: 2] = c.mode;
      w[spq_pkg::PH_BYTES_LSB +: 12] = c.bytes;
      w[spq_pkg::PH_ACT_LSB +: 2] = c.action;
      w[spq_pkg::PH_ERR_BIT] = e;
      w[spq_pkg::PH_DONE_BIT] = d;
      return w;
   endfunction

   // Bus handshakes and decode
   wire aw_hs = AWVALID & awready_q;
   wire w_hs = WVALID & wready_q;
   wire ar_hs = ARVALID & arready_q;
   wire do_wr = aw_held_q & w_held_q & ~bvalid_q;
   wire [3:0] wr_sel = reg_sel(aw_addr_q);
   wire [2:0] wr_pidx = ph_index(aw_addr_q);
   wire [3:0] rd_sel = reg_sel(ARADDR);
   wire [2:0] rd_pidx = ph_index(ARADDR);
   wire ctrl_wr = do_wr & (wr_sel == spq_pkg::SEL_CTRL) & w_strb_q[0];
   wire phase_wr = do_wr & (wr_sel == spq_pkg::SEL_PHASE);
   wire istat_wr = do_wr & (wr_sel == spq_pkg::SEL_ISTAT);
   wire imask_wr = do_wr & (wr_sel == spq_pkg::SEL_IMASK);
   wire [31:0] ph_new = wmerge(ph_word(cfg_q[wr_pidx], 1'b0, 1'b0), w_data_q, w_strb_q);
   wire [31:0] mask_new = wmerge({30'h0, imask_q}, w_data_q, w_strb_q);

   // Sequencer events
   wire start_req = ctrl_wr & w_data_q[spq_pkg::START_BIT] & (state_q == spq_pkg::ST_IDLE);
   wire phase_fin = (state_q == spq_pkg::ST_RUN) & PHASE_ACK;
   wire last_phase = (idx_q == pcnt_q);
   wire comm_fin = (state_q == spq_pkg::ST_DMA) & DMA_DONE;

   // Read data selection
   wire [31:0] ctrl_word = {25'h0, pcnt_q, 1'b0, err_q, done_q, 1'b0};
   wire [31:0] stat_word = {25'h0, idx_q, 3'h0, busy_q};
   wire [31:0] rd_word =
      (rd_sel == spq_pkg::SEL_CTRL) ? ctrl_word :
      (rd_sel == spq_pkg::SEL_PHASE) ?
         ph_word(cfg_q[rd_pidx], ph_err_q[rd_pidx], ph_done_q[rd_pidx]) :
      (rd_sel == spq_pkg::SEL_ISTAT) ? {30'h0, istat_q} :
      (rd_sel == spq_pkg::SEL_IMASK) ? {30'h0, imask_q} :
      (rd_sel == spq_pkg::SEL_STATUS) ? stat_word : 32'h0000_0000;

   // Next state of sequencer
   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      case (state_q)
         spq_pkg::ST_IDLE: begin
            if (start_req) begin
               state_d = spq_pkg::ST_RUN;
               idx_d = 3'h0;
            end
         end
         spq_pkg::ST_RUN: begin
            if (phase_fin) begin
               if (last_phase)
                  state_d = spq_pkg::ST_DMA;
               else
                  idx_d = idx_q + 3'h1;
            end
         end
         spq_pkg::ST_DMA: begin
            if (DMA_DONE)
               state_d = spq_pkg::ST_IDLE;
         end
         default: begin
            state_d = spq_pkg::ST_IDLE;
         end
      endcase
   end

   // Flag next values
   always_comb begin
      pcnt_d = ctrl_wr ? w_data_q[spq_pkg::PCNT_MSB:spq_pkg::PCNT_LSB] : pcnt_q;
      fail_d = start_req ? 1'b0 : (fail_q | (phase_fin & PHASE_FAIL));
      if (start_req)
         done_d = 1'b0;
      else if (comm_fin)
         done_d = 1'b1;
      else if (ctrl_wr & ~w_data_q[spq_pkg::DONE_BIT])
         done_d = 1'b0;
      else
         done_d = done_q;
      if (start_req)
         err_d = 1'b0;
      else if (comm_fin & fail_q)
         err_d = 1'b1;
      else if (ctrl_wr & ~w_data_q[spq_pkg::ERROR_BIT])
         err_d = 1'b0;
      else
         err_d = err_q;
      istat_d = (istat_q & ~(istat_wr & w_strb_q[0] ? w_data_q[1:0] : 2'h0))
                | {comm_fin & fail_q, comm_fin};
      imask_d = imask_wr ? mask_new[1:0] : imask_q;
      aw_held_d = (aw_held_q | aw_hs) & ~do_wr;
      w_held_d = (w_held_q | w_hs) & ~do_wr;
   end

   // Sequencer and control state
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_q <= spq_pkg::ST_IDLE;
         idx_q <= 3'h0;
         pcnt_q <= spq_pkg::PCNT_RST;
         done_q <= spq_pkg::DONE_RST;
         err_q <= spq_pkg::ERROR_RST;
         fail_q <= 1'b0;
         istat_q <= spq_pkg::INT_RST;
         imask_q <= spq_pkg::INT_RST;
      end else if (CE) begin
         state_q <= state_d;
         idx_q <= idx_d;
         pcnt_q <= pcnt_d;
         done_q <= done_d;
         err_q <= err_d;
         fail_q <= fail_d;
         istat_q <= istat_d;
         imask_q <= imask_d;
      end
   end

   // Per-phase configuration and result bits
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < NPHASE; i++)
            cfg_q[i] <= spq_pkg::PHASE_RST;
         ph_done_q <= '0;
         ph_err_q <= '0;
      end else if (CE) begin
         if (phase_wr) begin
            cfg_q[wr_pidx].mode <= ph_new[spq_pkg::PH_MODE_LSB +: 2];
            cfg_q[wr_pidx].bytes <= ph_new[spq_pkg::PH_BYTES_LSB +: 12];
            cfg_q[wr_pidx].action <= ph_new[spq_pkg::PH_ACT_LSB +: 2];
         end
         if (start_req) begin
            ph_done_q <= '0;
            ph_err_q <= '0;
         end else if (phase_fin) begin
            ph_done_q[idx_q] <= 1'b1;
            ph_err_q[idx_q] <= PHASE_FAIL;
         end
      end
   end

   // Outputs toward engine and interrupt
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         req_q <= 1'b0;
         pidx_q <= 3'h0;
         pcfg_q <= spq_pkg::PHASE_RST;
         busy_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (CE) begin
         req_q <= (state_d == spq_pkg::ST_RUN) & ~phase_fin;
         pidx_q <= idx_d;
         pcfg_q <= cfg_q[idx_d];
         busy_q <= (state_d != spq_pkg::ST_IDLE);
         irq_q <= |(istat_d & imask_d);
      end
   end

   // AXI4-Lite slave
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= spq_pkg::RESP_OKAY;
      end else if (CE) begin
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         if (aw_hs)
            aw_addr_q <= AWADDR;
         if (w_hs) begin
            w_data_q <= WDATA;
            w_strb_q <= WSTRB;
         end
         awready_q <= ~aw_held_d;
         wready_q <= ~w_held_d;
         if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_sel == spq_pkg::SEL_NONE) ? spq_pkg::RESP_SLVERR : spq_pkg::RESP_OKAY;
         end else if (BREADY)
            bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= spq_pkg::RESP_OKAY;
      end else if (CE) begin
         if (ar_hs) begin
            rvalid_q <= 1'b1;
            arready_q <= 1'b0;
            rdata_q <= rd_word;
            rresp_q <= (rd_sel == spq_pkg::SEL_NONE) ? spq_pkg::RESP_SLVERR : spq_pkg::RESP_OKAY;
         end else if (rvalid_q & RREADY) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   assign AWREADY = awready_q;
   assign WREADY = wready_q;
   assign BVALID = bvalid_q;
   assign BRESP = bresp_q;
   assign ARREADY = arready_q;
   assign RVALID = rvalid_q;
   assign RDATA = rdata_q;
   assign RRESP = rresp_q;
   assign PHASE_REQ = req_q;
   assign PHASE_IDX = pidx_q;
   assign PHASE_CFG = pcfg_q;
   assign BUSY = busy_q;
   assign IRQ = irq_q;

   // Checks
   a_pcnt_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN || !CE)
      ctrl_wr |=> pcnt_q == $past(w_data_q[spq_pkg::PCNT_MSB:spq_pkg::PCNT_LSB]))
      else $error("phase count not written");
   a_err_set: assert property (@(posedge SYS_CLK) disable iff (!RSTN || !CE)
      comm_fin && fail_q |=> err_q && istat_q[spq_pkg::INT_ERR_BIT])
      else $error("error flag not set on failed phase");
   a_flag_wzero: assert property (@(posedge SYS_CLK) disable iff (!RSTN || !CE)
      ctrl_wr && !w_data_q[spq_pkg::DONE_BIT] && !comm_fin |=> !done_q)
      else $error("done flag not cleared by zero write");
   a_start_clear: assert property (@(posedge SYS_CLK) disable iff (!RSTN || !CE)
      start_req |=> !done_q && !err_q && BUSY ##1 PHASE_REQ)
      else $error("start did not clear flags or begin");
   a_done_after_dma: assert property (@(posedge SYS_CLK) disable iff (!RSTN || !CE)
      $rose(done_q) |-> $past(DMA_DONE) && $past(state_q) == spq_pkg::ST_DMA)
      else $error("done raised before DMA end");
   a_ctrl_layout: assert property (@(posedge SYS_CLK) disable iff (!RSTN || !CE)
      ar_hs && rd_sel == spq_pkg::SEL_CTRL |=>
         RDATA[2:1] == {$past(err_q), $past(done_q)} && RDATA[3] == 1'b0)
      else $error("control word layout wrong");
   a_phase_step: assert property (@(posedge SYS_CLK) disable iff (!RSTN || !CE)
      phase_fin && !last_phase |=> idx_q == $past(idx_q) + 3'h1 && PHASE_IDX == idx_q)
      else $error("phase index did not advance");
   a_last_phase: assert property (@(posedge SYS_CLK) disable iff (!RSTN || !CE)
      phase_fin && last_phase |=> state_q == spq_pkg::ST_DMA && !PHASE_REQ)
      else $error("sequence did not end at phase count");
endmodule // spq_top

// ==== core/spq_pkg.sv ====
// Constants and types for the SPI phase sequence control and status block
package spq_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] PHASE0_OFS = 8'h10;
   localparam logic [7:0] PHASE_LAST_OFS = 8'h2c;
   localparam logic [7:0] INT_STAT_OFS = 8'h30;
   localparam logic [7:0] INT_MASK_OFS = 8'h34;
   localparam logic [7:0] STATUS_OFS = 8'h38;
   // Control register fields
   localparam int START_BIT = 0;
   localparam int DONE_BIT = 1;
   localparam int ERROR_BIT = 2;
   localparam int PCNT_LSB = 4;
   localparam int PCNT_MSB = 6;
   localparam logic [2:0] PCNT_RST = 3'h0;
   localparam logic DONE_RST = 1'b0;
   localparam logic ERROR_RST = 1'b0;
   // Phase register fields
   localparam int PH_DONE_BIT = 1;
   localparam int PH_ERR_BIT = 2;
   localparam int PH_ACT_LSB = 4;
   localparam int PH_BYTES_LSB = 8;
   localparam int PH_MODE_LSB = 20;
   // Interrupt status and mask fields
   localparam int INT_DONE_BIT = 0;
   localparam int INT_ERR_BIT = 1;
   localparam logic [1:0] INT_RST = 2'h0;
   // Status register fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_IDX_LSB = 4;
   // Register select codes
   localparam logic [3:0] SEL_CTRL = 4'h0;
   localparam logic [3:0] SEL_PHASE = 4'h1;
   localparam logic [3:0] SEL_ISTAT = 4'h2;
   localparam logic [3:0] SEL_IMASK = 4'h3;
   localparam logic [3:0] SEL_STATUS = 4'h4;
   localparam logic [3:0] SEL_NONE = 4'hf;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_DMA = 2'b10
   } spq_state_e;
   typedef struct packed {
      logic [1:0] mode;
      logic [11:0] bytes;
      logic [1:0] action;
   } spq_phase_s;
   localparam spq_phase_s PHASE_RST = '{mode: 2'h0, bytes: 12'h000, action: 2'h0};
endpackage

// ==== bench/spq_eng_model.sv ====
// Serial engine and DMA stand-in facing the phase sequencer
`timescale 1ns/1ns
module spq_eng_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Phase link
   input wire logic phase_req,
   input wire logic [2:0] phase_idx,
   output logic phase_ack,
   output logic phase_fail,
   output logic dma_done,
   // Test control
   input wire logic [1:0] slow,
   input wire logic [7:0] fail_mask,
   input wire logic dma_en
);
   logic [1:0] cnt_q;
   logic wait_q;
   // Answer each request after a chosen delay, then wait for it to drop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 2'h0;
         wait_q <= 1'b0;
         phase_ack <= 1'b0;
         phase_fail <= 1'b0;
         dma_done <= 1'b0;
      end else begin
         dma_done <= dma_en;
         phase_ack <= 1'b0;
         phase_fail <= ~phase_fail;
         if (phase_ack) begin
            wait_q <= 1'b1;
         end else if (wait_q) begin
            wait_q <= phase_req;
         end else if (phase_req && cnt_q == slow) begin
            phase_ack <= 1'b1;
            phase_fail <= fail_mask[phase_idx];
            cnt_q <= 2'h0;
         end else if (phase_req) begin
            cnt_q <= cnt_q + 2'h1;
         end
      end
   end
endmodule // spq_eng_model

// ==== bench/spi_phase_sequence_status_tb.sv ====
// Self-checking bench for the phase sequencer
`timescale 1ns/1ns
module spi_phase_sequence_status_tb;
   logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic bvalid, arready, rvalid, req, ack, fail, dma, dma_en, busy, irq, rq_q, ce;
   logic [7:0] awaddr, araddr, fm;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, slow;
   logic [2:0] idx;
   logic [15:0] x;
   spq_pkg::spq_phase_s pcfg;
   spq_pkg::spq_phase_s cfg [8];
   logic [1:0] bq [$];
   logic [33:0] rq [$];
   int n_errors, checks_done, nreq, nb, n, e;
   int ns [3] = '{0, 3, 7};
   logic [7:0] fms [3] = '{8'h00, 8'h0a, 8'h80};
   spq_top spq_top_i (.SYS_CLK(clk), .RSTN(rstn), .CE(ce), .AWADDR(awaddr),
      .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
      .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
      .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
      .RREADY(rready), .PHASE_REQ(req), .PHASE_IDX(idx), .PHASE_CFG(pcfg), .PHASE_ACK(ack),
      .PHASE_FAIL(fail), .DMA_DONE(dma), .BUSY(busy), .IRQ(irq));
   spq_eng_model spq_eng_model_i (.clk(clk), .rst_n(rstn), .phase_req(req), .phase_idx(idx),
      .phase_ack(ack), .phase_fail(fail), .dma_done(dma), .slow(slow), .fail_mask(fm),
      .dma_en(dma_en));
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [31:0] ctl(input int pc, input int er, input int dn);
      return 32'((pc << 4) | (er << 2) | (dn << 1));
   endfunction
   task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] ex);
      checks_done++;
      if (s !== ex) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, ex, s);
      end
   endtask
   task automatic summarize;
      if (n_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      bq.push_back(r);
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      rq.push_back({r, d});
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask
   // Result watcher: bus answers and phase requests
   always @(posedge clk) begin
      if (bvalid && bready) chk("bresp", 34'(bresp), 34'(bq.pop_front()));
      if (rvalid && rready) chk("read", {rresp, rdata}, rq.pop_front());
      if (req && !rq_q) begin
         chk("phase_idx", 34'(idx), 34'(nreq - nb));
         chk("phase_cfg", 34'(pcfg), 34'(cfg[idx]));
         nreq++;
      end
      rq_q = req;
   end
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (6000) @(posedge clk);
      n_errors++;
      summarize();
   end
   initial begin
      {rstn, awvalid, wvalid, bready, arvalid, rready, dma_en} = 7'h00;
      ce = 1'b1;
      {awaddr, araddr, fm, wdata, wstrb, slow} = 62'h0;
      x = 16'h5b47;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      rd(spq_pkg::CTRL_OFS, 32'h0, spq_pkg::RESP_OKAY);
      rd(8'h3c, 32'h0, spq_pkg::RESP_SLVERR);
      wr(8'h3c, 32'hffffffff, spq_pkg::RESP_SLVERR);
      wr(spq_pkg::INT_MASK_OFS, 32'h3, spq_pkg::RESP_OKAY);
      for (int k = 0; k < 3; k++) begin
         n = ns[k];
         fm <= fms[k];
         e = int'(|(fms[k] & 8'((16'h2 << n) - 1)));
         for (int i = 0; i < 8; i++) begin
            x = lfsr(x);
            cfg[i] = {1'b0, x[14:0]};
            wr(8'(spq_pkg::PHASE0_OFS + 4 * i),
               {10'h0, cfg[i].mode, cfg[i].bytes, 2'h0, cfg[i].action, 4'h0}, 2'h0);
         end
         slow <= x[1:0];
         nb = nreq;
         wr(spq_pkg::CTRL_OFS, ctl(n, 0, 0) | 32'h1, spq_pkg::RESP_OKAY);
         rd(spq_pkg::CTRL_OFS, ctl(n, 0, 0), spq_pkg::RESP_OKAY);
         do @(negedge clk); while (nreq - nb < n + 1 || req);
         repeat (20) @(negedge clk);
         chk("busy", 34'(busy), 34'h1);
         rd(spq_pkg::CTRL_OFS, ctl(n, 0, 0), spq_pkg::RESP_OKAY);
         @(posedge clk);
         dma_en <= 1'b1;
         ce <= 1'b0;
         repeat (4) @(negedge clk);
         chk("frozen_busy", 34'(busy), 34'h1);
         @(posedge clk);
         ce <= 1'b1;
         do @(negedge clk); while (busy);
         @(posedge clk);
         dma_en <= 1'b0;
         chk("phases", 34'(nreq - nb), 34'(n + 1));
         rd(spq_pkg::CTRL_OFS, ctl(n, e, 1), spq_pkg::RESP_OKAY);
         @(negedge clk);
         chk("irq", 34'(irq), 34'h1);
         rd(spq_pkg::INT_STAT_OFS, 32'(e * 2 + 1), spq_pkg::RESP_OKAY);
         rd(8'(spq_pkg::PHASE0_OFS + 4 * n),
            {10'h0, cfg[n].mode, cfg[n].bytes, 2'h0, cfg[n].action, 1'b0, fms[k][n], 2'b10},
            spq_pkg::RESP_OKAY);
         wr(spq_pkg::INT_STAT_OFS, 32'h3, spq_pkg::RESP_OKAY);
         repeat (3) @(negedge clk);
         chk("irq", 34'(irq), 34'h0);
         wr(spq_pkg::CTRL_OFS, ctl(n, k != 2, k != 2), spq_pkg::RESP_OKAY);
         rd(spq_pkg::CTRL_OFS, ctl(n, e * (k != 2), k != 2), spq_pkg::RESP_OKAY);
      end
      summarize();
   end
endmodule // spi_phase_sequence_status_tb
